// ---- design/ldc_pkg.sv ----
// ldc_pkg: register map, field layout, encodings and timing of the legacy dma controller
// assumes a 20 MHz mclk and a 9-bit wishbone byte address
package ldc_pkg;
	localparam int NCH = 8;
	localparam logic [2:0] BM_CH = 3'h4;
	// per channel word offsets inside a 0x20 window, channel n at n*0x20
	localparam logic [4:0] CH_BASE_ADDR = 5'h00;
	localparam logic [4:0] CH_BASE_CNT = 5'h04;
	localparam logic [4:0] CH_CUR_ADDR = 5'h08;
	localparam logic [4:0] CH_CUR_CNT = 5'h0C;
	localparam logic [4:0] CH_MODE = 5'h10;
	// global registers
	localparam logic [8:0] REG_CMD = 9'h100;
	localparam logic [8:0] REG_MASK = 9'h104;
	localparam logic [8:0] REG_STATUS = 9'h108;
	localparam logic [8:0] REG_FAST = 9'h10C;
	// mode fields
	localparam int MODE_AUTO = 2;
	localparam int MODE_DEC = 3;
	localparam int MODE_SINGLE = 4;
	localparam logic [1:0] TYPE_VERIFY = 2'h0;
	localparam logic [1:0] TYPE_TO_MEM = 2'h1;
	localparam logic [1:0] TYPE_FROM_MEM = 2'h2;
	localparam int CMD_EN = 0;
	localparam logic [7:0] MASK_RST = 8'hFF;
	localparam logic [7:0] FAST_ALLOWED = 8'hEF;
	localparam int FAST_MAX = 2;
	// idle gap between units of a normal channel
	localparam int CLK_NS = 50;
	localparam int GAP_NS = 150;
	localparam logic [2:0] GAP_CYC = 3'((GAP_NS + CLK_NS - 1) / CLK_NS);
	// lad nibbles
	localparam logic [3:0] LAD_START = 4'h0;
	localparam logic [3:0] LAD_CT_FROM_MEM = 4'h8;
	localparam logic [3:0] LAD_CT_TO_MEM = 4'hA;
	localparam logic [3:0] LAD_TAR = 4'hF;
	localparam logic [3:0] LAD_SIZE_BYTE = 4'h0;
	localparam logic [3:0] LAD_SIZE_WORD = 4'h1;
	localparam logic [3:0] SYNC_READY = 4'h0;
	localparam logic [3:0] SYNC_MORE = 4'h9;
	localparam logic [3:0] SYNC_ERR = 4'hA;
	localparam logic [7:0] SYNC_TMO = 8'h40;
	// serial request frame: start, three channel bits, active bit
	localparam logic [2:0] REQ_LAST = 3'h4;
	localparam logic [1:0] GNT_LAST = 2'h3;
	typedef enum {S_IDLE, S_MEMRD, S_LPC, S_MEMWR, S_GRANT, S_STEP, S_GAP, S_BM} ldc_state_t;
	typedef enum {L_IDLE, L_START, L_CTYP, L_CHAN, L_SIZE, L_HDATA, L_TAR1, L_TAR2, L_SYNC, L_PDATA,
		L_TARE1, L_TARE2} ldc_lpc_state_t;
	function automatic logic [3:0] ldc_popcnt(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction : ldc_popcnt
	function automatic logic [2:0] ldc_first(input logic [7:0] v);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				c = 3'(i);
			end
		end
		return c;
	endfunction : ldc_first
endpackage : ldc_pkg

// ---- design/ldc_lpc_cycle.sv ----
// ldc_lpc_cycle: one lpc dma cycle per start pulse, host end of lad
// assumes lad_in comes from the pin; it is resynchronised here, so the host sees the peripheral's lad two cycles late
`timescale 1ns/1ns
module ldc_lpc_cycle (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// request from the engine
	input wire logic start,
	input wire logic [2:0] ch,
	input wire logic tc,
	input wire logic wide,
	input wire logic to_mem,
	input wire logic [15:0] wdata,
	output logic done,
	output logic err,
	output logic [15:0] rdata,
	// lpc pins
	input wire logic [3:0] lad_in,
	output logic [3:0] lad_out,
	output logic lad_oe,
	output logic lframe_n
);
	ldc_pkg::ldc_lpc_state_t st_r, st_nxt;
	logic [3:0] lad_m_r, lad_s_r;
	logic [1:0] nib_r, nib_nxt;
	logic [7:0] tmo_r, tmo_nxt;
	logic [15:0] wd_r, wd_nxt, rd_nxt;
	logic [2:0] ch_r, ch_nxt;
	logic tc_r, tc_nxt, wide_r, wide_nxt, tm_r, tm_nxt, err_nxt, done_nxt, oe_nxt, fr_nxt;
	logic [3:0] out_nxt;
	logic [1:0] last;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lad_m_r <= 4'hF;
			lad_s_r <= 4'hF;
		end else begin
			lad_m_r <= lad_in;
			lad_s_r <= lad_m_r;
		end
	end
	always_comb begin
		st_nxt = st_r;
		nib_nxt = nib_r;
		tmo_nxt = tmo_r;
		wd_nxt = wd_r;
		rd_nxt = rdata;
		ch_nxt = ch_r;
		tc_nxt = tc_r;
		wide_nxt = wide_r;
		tm_nxt = tm_r;
		err_nxt = err;
		done_nxt = 1'b0;
		oe_nxt = 1'b1;
		fr_nxt = 1'b1;
		out_nxt = ldc_pkg::LAD_TAR;
		last = wide_r ? 2'h3 : 2'h1;
		case (st_r)
			ldc_pkg::L_IDLE: begin
				oe_nxt = 1'b0;
				if (start) begin
					st_nxt = ldc_pkg::L_START;
					fr_nxt = 1'b0;
					oe_nxt = 1'b1;
					out_nxt = ldc_pkg::LAD_START; // RULE8
					ch_nxt = ch;
					tc_nxt = tc;
					wide_nxt = wide;
					tm_nxt = to_mem;
					wd_nxt = wdata;
					err_nxt = 1'b0;
				end
			end
			ldc_pkg::L_START: begin
				st_nxt = ldc_pkg::L_CTYP;
				out_nxt = tm_r ? ldc_pkg::LAD_CT_TO_MEM : ldc_pkg::LAD_CT_FROM_MEM; // RULE8
			end
			ldc_pkg::L_CTYP: begin
				st_nxt = ldc_pkg::L_CHAN;
				out_nxt = {tc_r, ch_r}; // RULE8
			end
			ldc_pkg::L_CHAN: begin
				st_nxt = ldc_pkg::L_SIZE;
				out_nxt = wide_r ? ldc_pkg::LAD_SIZE_WORD : ldc_pkg::LAD_SIZE_BYTE; // RULE8
			end
			ldc_pkg::L_SIZE: begin
				nib_nxt = 2'h0;
				if (tm_r) begin
					st_nxt = ldc_pkg::L_TAR1;
				end else begin
					st_nxt = ldc_pkg::L_HDATA;
					out_nxt = wd_r[3:0];
				end
			end
			ldc_pkg::L_HDATA: begin
				if (nib_r == last) begin
					st_nxt = ldc_pkg::L_TAR1;
				end else begin
					nib_nxt = nib_r + 2'h1;
					out_nxt = wd_r[{nib_nxt, 2'b00} +: 4];
				end
			end
			ldc_pkg::L_TAR1: begin
				st_nxt = ldc_pkg::L_TAR2;
				oe_nxt = 1'b0;
				nib_nxt = 2'h0;
			end
			ldc_pkg::L_TAR2: begin
				st_nxt = ldc_pkg::L_SYNC;
				oe_nxt = 1'b0;
				tmo_nxt = 8'h00;
			end
			ldc_pkg::L_SYNC: begin
				oe_nxt = 1'b0;
				tmo_nxt = tmo_r + 8'h01;
				if (lad_s_r == ldc_pkg::SYNC_READY || lad_s_r == ldc_pkg::SYNC_MORE) begin
					st_nxt = tm_r ? ldc_pkg::L_PDATA : ldc_pkg::L_TARE1;
				end else if (lad_s_r == ldc_pkg::SYNC_ERR || tmo_r == ldc_pkg::SYNC_TMO) begin
					err_nxt = 1'b1;
					st_nxt = ldc_pkg::L_TARE1;
				end
			end
			ldc_pkg::L_PDATA: begin
				oe_nxt = 1'b0;
				rd_nxt[{nib_r, 2'b00} +: 4] = lad_s_r;
				nib_nxt = nib_r + 2'h1;
				if (nib_r == last) begin
					st_nxt = ldc_pkg::L_TARE1;
				end else if (nib_r[0]) begin
					st_nxt = ldc_pkg::L_SYNC;
					tmo_nxt = 8'h00;
				end
			end
			ldc_pkg::L_TARE1: begin
				oe_nxt = 1'b0;
				st_nxt = ldc_pkg::L_TARE2;
			end
			default: begin
				oe_nxt = 1'b0;
				st_nxt = ldc_pkg::L_IDLE;
				done_nxt = 1'b1;
			end
		endcase
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= ldc_pkg::L_IDLE;
			nib_r <= 2'h0;
			tmo_r <= 8'h00;
			wd_r <= 16'h0000;
			rdata <= 16'h0000;
			ch_r <= 3'h0;
			tc_r <= 1'b0;
			wide_r <= 1'b0;
			tm_r <= 1'b0;
			err <= 1'b0;
			done <= 1'b0;
			lad_oe <= 1'b0;
			lframe_n <= 1'b1;
			lad_out <= 4'hF;
		end else begin
			st_r <= st_nxt;
			nib_r <= nib_nxt;
			tmo_r <= tmo_nxt;
			wd_r <= wd_nxt;
			rdata <= rd_nxt;
			ch_r <= ch_nxt;
			tc_r <= tc_nxt;
			wide_r <= wide_nxt;
			tm_r <= tm_nxt;
			err <= err_nxt;
			done <= done_nxt;
			lad_oe <= oe_nxt;
			lframe_n <= fr_nxt;
			lad_out <= out_nxt;
		end
	end
	chk_lpc_start_frame: assert property (@(posedge mclk) disable iff (!reset_n) // RULE8
		(st_r == ldc_pkg::L_IDLE && start) |=> (!lframe_n && lad_oe && lad_out == ldc_pkg::LAD_START)
		##1 (lframe_n && lad_out[3:2] == 2'b10)) else $error("lpc dma frame header wrong");
endmodule : ldc_lpc_cycle

// ---- design/ldc_top.sv ----
// ldc_top: seven channel legacy dma engine with wishbone registers, lpc and sideband request paths
// assumes a classic wishbone master on mclk and a memory port that answers with mem_ack
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
// What this block does
// RULE1: seven programmable channels from two cascaded halves
// RULE2: channels 0-3 move bytes, count per byte
// RULE3: channels 5-7 move words, count per word
// RULE4: at most two channels use fast timing
// RULE5: channel 4 only grants a bus master
// RULE6: lpc and sideband requests share one engine
// RULE7: sideband requests and grants are serial encoded
// RULE8: lpc requests on ldrq, cycles on lad
// RULE9: single, demand, verify and increment modes
// RULE10: every register reads back what it holds
// RULE11: step address and count, terminal count completes
module ldc_top (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [8:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// lpc
	input wire logic ldrq_n,
	input wire logic [3:0] lad_in,
	output logic [3:0] lad_out,
	output logic lad_oe,
	output logic lframe_n,
	// sideband dma path
	input wire logic [1:0] sb_req_n,
	output logic [1:0] sb_gnt_n,
	// bus master channel
	input wire logic bm_req,
	output logic bm_gnt,
	// memory port
	output logic mem_req,
	output logic mem_we,
	output logic mem_wide,
	output logic [23:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack
);
	ldc_pkg::ldc_state_t st_r, st_nxt;
	logic [23:0] ba_r [8], ba_nxt [8], ca_r [8], ca_nxt [8];
	logic [15:0] bc_r [8], bc_nxt [8], cc_r [8], cc_nxt [8];
	logic [4:0] md_r [8], md_nxt [8];
	logic [7:0] cmd_r, cmd_nxt, mask_r, mask_nxt, tcs_r, tcs_nxt, fast_r, fast_nxt;
	logic [7:0] rq_lpc_r, rq_lpc_nxt, rq_sb_r, rq_sb_nxt, skip_r, skip_nxt, pend, pend2;
	logic [7:0] sbl_r, sbl_nxt;
	logic [3:0] pin_m_r, pin_s_r;
	logic [2:0] dcnt_r [3], dcnt_nxt [3], dsh_r [3], dsh_nxt [3];
	logic [2:0] ch_r, ch_nxt, gap_r, gap_nxt;
	logic [1:0] gcnt_r, gcnt_nxt, gnt_nxt;
	logic [31:0] rd_nxt;
	logic ack_nxt, wr, bm_nxt, mreq_nxt, mwe_nxt, lst_r, lst_nxt;
	logic [23:0] maddr_nxt;
	logic [15:0] mwd_nxt, dat_r, dat_nxt, lpc_rdata;
	logic lpc_done, lpc_err, wide, tcn;
	logic [4:0] md;
	logic [7:0] fw;
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge
	// pins from other parties: ldrq, two sideband requests, bus master request
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pin_m_r <= 4'h7;
			pin_s_r <= 4'h7;
		end else begin
			pin_m_r <= {bm_req, sb_req_n, ldrq_n};
			pin_s_r <= pin_m_r;
		end
	end
	ldc_lpc_cycle u_lpc (
		.mclk(mclk),
		.reset_n(reset_n),
		.start(lst_r),
		.ch(ch_r),
		.tc(tcn),
		.wide(wide),
		.to_mem(md[1:0] == ldc_pkg::TYPE_TO_MEM),
		.wdata(dat_r),
		.done(lpc_done),
		.err(lpc_err),
		.rdata(lpc_rdata),
		.lad_in(lad_in),
		.lad_out(lad_out),
		.lad_oe(lad_oe),
		.lframe_n(lframe_n)
	);
	assign md = md_r[ch_r];
	assign wide = ch_r[2]; // RULE2 RULE3
	assign tcn = (cc_r[ch_r] == 16'h0000);
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign fw = wb_dat_i[7:0] & ldc_pkg::FAST_ALLOWED;
	// one engine, both request paths feed the same pending vector
	assign pend = (rq_lpc_r | rq_sb_r) & ~mask_r & {8{cmd_r[ldc_pkg::CMD_EN]}}; // RULE1 RULE6
	assign pend2 = ((pend & ~skip_r) != 8'h00) ? (pend & ~skip_r) : pend;
	always_comb begin
		st_nxt = st_r;
		ba_nxt = ba_r;
		bc_nxt = bc_r;
		ca_nxt = ca_r;
		cc_nxt = cc_r;
		md_nxt = md_r;
		cmd_nxt = cmd_r;
		mask_nxt = mask_r;
		tcs_nxt = tcs_r;
		fast_nxt = fast_r;
		rq_lpc_nxt = rq_lpc_r;
		rq_sb_nxt = rq_sb_r;
		sbl_nxt = sbl_r;
		skip_nxt = skip_r;
		dcnt_nxt = dcnt_r;
		dsh_nxt = dsh_r;
		ch_nxt = ch_r;
		gap_nxt = gap_r;
		gcnt_nxt = gcnt_r;
		gnt_nxt = 2'b11;
		bm_nxt = 1'b0;
		mreq_nxt = mem_req;
		mwe_nxt = mem_we;
		maddr_nxt = mem_addr;
		mwd_nxt = mem_wdata;
		dat_nxt = dat_r;
		lst_nxt = 1'b0;
		ack_nxt = wb_cyc_i && wb_stb_i && !wb_ack_o;
		rd_nxt = 32'h0000_0000;
		// register reads, every programmed register visible for save and restore; engine state, skip and sideband line latches are not
		if (!wb_adr_i[8]) begin
			if (wb_adr_i[4:0] == ldc_pkg::CH_BASE_ADDR) begin
				rd_nxt = {8'h00, ba_r[wb_adr_i[7:5]]}; // RULE10
			end else if (wb_adr_i[4:0] == ldc_pkg::CH_BASE_CNT) begin
				rd_nxt = {16'h0000, bc_r[wb_adr_i[7:5]]};
			end else if (wb_adr_i[4:0] == ldc_pkg::CH_CUR_ADDR) begin
				rd_nxt = {8'h00, ca_r[wb_adr_i[7:5]]};
			end else if (wb_adr_i[4:0] == ldc_pkg::CH_CUR_CNT) begin
				rd_nxt = {16'h0000, cc_r[wb_adr_i[7:5]]};
			end else if (wb_adr_i[4:0] == ldc_pkg::CH_MODE) begin
				rd_nxt = {27'h0, md_r[wb_adr_i[7:5]]};
			end
		end else if (wb_adr_i == ldc_pkg::REG_CMD) begin
			rd_nxt = {24'h0, cmd_r};
		end else if (wb_adr_i == ldc_pkg::REG_MASK) begin
			rd_nxt = {24'h0, mask_r};
		end else if (wb_adr_i == ldc_pkg::REG_STATUS) begin
			rd_nxt = {16'h0, rq_lpc_r | rq_sb_r, tcs_r};
		end else if (wb_adr_i == ldc_pkg::REG_FAST) begin
			rd_nxt = {24'h0, fast_r};
		end
		// register writes; hardware updates below override them
		if (wr) begin
			if (!wb_adr_i[8]) begin
				if (wb_adr_i[4:0] == ldc_pkg::CH_BASE_ADDR) begin
					ba_nxt[wb_adr_i[7:5]] = 24'(merge({8'h00, ba_r[wb_adr_i[7:5]]}, wb_dat_i, wb_sel_i));
				end else if (wb_adr_i[4:0] == ldc_pkg::CH_BASE_CNT) begin
					bc_nxt[wb_adr_i[7:5]] = 16'(merge({16'h0, bc_r[wb_adr_i[7:5]]}, wb_dat_i, wb_sel_i));
				end else if (wb_adr_i[4:0] == ldc_pkg::CH_CUR_ADDR) begin
					ca_nxt[wb_adr_i[7:5]] = 24'(merge({8'h00, ca_r[wb_adr_i[7:5]]}, wb_dat_i, wb_sel_i)); // RULE10
				end else if (wb_adr_i[4:0] == ldc_pkg::CH_CUR_CNT) begin
					cc_nxt[wb_adr_i[7:5]] = 16'(merge({16'h0, cc_r[wb_adr_i[7:5]]}, wb_dat_i, wb_sel_i));
				end else if (wb_adr_i[4:0] == ldc_pkg::CH_MODE && wb_sel_i[0]) begin
					md_nxt[wb_adr_i[7:5]] = wb_dat_i[4:0];
				end
			end else if (wb_sel_i[0]) begin
				if (wb_adr_i == ldc_pkg::REG_CMD) begin
					cmd_nxt = wb_dat_i[7:0];
				end else if (wb_adr_i == ldc_pkg::REG_MASK) begin
					mask_nxt = wb_dat_i[7:0];
				end else if (wb_adr_i == ldc_pkg::REG_STATUS) begin
					tcs_nxt = wb_dat_i[7:0];
				end else if (wb_adr_i == ldc_pkg::REG_FAST && ldc_pkg::ldc_popcnt(fw) <= 4'(ldc_pkg::FAST_MAX)) begin
					fast_nxt = fw; // RULE4
				end
			end
		end
		// serial request frames: line 0 ldrq, lines 1 and 2 sideband
		for (int i = 0; i < 3; i++) begin
			if (dcnt_r[i] == 3'h0) begin
				if (!pin_s_r[i]) begin
					dcnt_nxt[i] = 3'h1; // RULE7 RULE8
				end
			end else if (dcnt_r[i] == ldc_pkg::REQ_LAST) begin
				dcnt_nxt[i] = 3'h0;
				if (i == 0) begin
					rq_lpc_nxt[dsh_r[i]] = pin_s_r[i];
				end else begin
					rq_sb_nxt[dsh_r[i]] = pin_s_r[i];
					sbl_nxt[dsh_r[i]] = (i == 2);
				end
			end else begin
				dsh_nxt[i] = {pin_s_r[i], dsh_r[i][2:1]};
				dcnt_nxt[i] = dcnt_r[i] + 3'h1;
			end
		end
		rq_lpc_nxt[ldc_pkg::BM_CH] = 1'b0; // RULE5
		rq_sb_nxt[ldc_pkg::BM_CH] = 1'b0;
		case (st_r)
			ldc_pkg::S_IDLE: begin
				if (pend2[3:0] != 4'h0 || (!(pin_s_r[3] && !mask_r[ldc_pkg::BM_CH] && cmd_r[ldc_pkg::CMD_EN])
					&& pend2 != 8'h00)) begin
					ch_nxt = ldc_pkg::ldc_first(pend2);
					skip_nxt = 8'h00;
					if (rq_lpc_r[ch_nxt]) begin
						if (md_r[ch_nxt][1:0] == ldc_pkg::TYPE_FROM_MEM) begin
							st_nxt = ldc_pkg::S_MEMRD;
							mreq_nxt = 1'b1;
							mwe_nxt = 1'b0;
							maddr_nxt = ca_r[ch_nxt];
						end else begin
							st_nxt = ldc_pkg::S_LPC;
							lst_nxt = 1'b1;
						end
					end else begin
						st_nxt = ldc_pkg::S_GRANT;
						gnt_nxt[sbl_r[ch_nxt]] = 1'b0; // RULE7
						gcnt_nxt = 2'h0;
					end
				end else if (pin_s_r[3] && !mask_r[ldc_pkg::BM_CH] && cmd_r[ldc_pkg::CMD_EN]) begin
					st_nxt = ldc_pkg::S_BM;
					ch_nxt = ldc_pkg::BM_CH;
					bm_nxt = 1'b1; // RULE5
				end
			end
			ldc_pkg::S_BM: begin
				bm_nxt = pin_s_r[3];
				if (!pin_s_r[3]) begin
					st_nxt = ldc_pkg::S_IDLE;
				end
			end
			ldc_pkg::S_MEMRD: begin
				if (mem_ack) begin
					mreq_nxt = 1'b0;
					dat_nxt = mem_rdata;
					lst_nxt = 1'b1;
					st_nxt = ldc_pkg::S_LPC;
				end
			end
			ldc_pkg::S_LPC: begin
				if (lpc_done) begin
					if (md[1:0] == ldc_pkg::TYPE_TO_MEM && !lpc_err) begin
						st_nxt = ldc_pkg::S_MEMWR;
						mreq_nxt = 1'b1;
						mwe_nxt = 1'b1;
						maddr_nxt = ca_r[ch_r];
						mwd_nxt = lpc_rdata;
					end else begin
						st_nxt = ldc_pkg::S_STEP; // RULE9
					end
				end
			end
			ldc_pkg::S_MEMWR: begin
				if (mem_ack) begin
					mreq_nxt = 1'b0;
					st_nxt = ldc_pkg::S_STEP;
				end
			end
			ldc_pkg::S_GRANT: begin
				gnt_nxt[sbl_r[ch_r]] = (gcnt_r == ldc_pkg::GNT_LAST) ? 1'b1 : ch_r[gcnt_r];
				gcnt_nxt = gcnt_r + 2'h1;
				if (gcnt_r == ldc_pkg::GNT_LAST) begin
					// a fresh frame for this channel in the same cycle keeps its request
					rq_sb_nxt[ch_r] = rq_sb_nxt[ch_r] && ((dcnt_r[1] == ldc_pkg::REQ_LAST && dsh_r[1] == ch_r)
						|| (dcnt_r[2] == ldc_pkg::REQ_LAST && dsh_r[2] == ch_r));
					st_nxt = ldc_pkg::S_STEP;
				end
			end
			ldc_pkg::S_STEP: begin
				if (md[ldc_pkg::MODE_DEC]) begin
					ca_nxt[ch_r] = ca_r[ch_r] - {22'h0, wide, !wide}; // RULE2 RULE3 RULE9
				end else begin
					ca_nxt[ch_r] = ca_r[ch_r] + {22'h0, wide, !wide}; // RULE9
				end
				cc_nxt[ch_r] = cc_r[ch_r] - 16'h0001; // RULE11
				if (tcn) begin
					tcs_nxt[ch_r] = 1'b1; // RULE11
					if (md[ldc_pkg::MODE_AUTO]) begin
						ca_nxt[ch_r] = ba_r[ch_r];
						cc_nxt[ch_r] = bc_r[ch_r];
					end else begin
						mask_nxt[ch_r] = 1'b1;
					end
				end
				// single mode lets another pending channel in before this one again
				skip_nxt[ch_r] = md[ldc_pkg::MODE_SINGLE]; // RULE9
				gap_nxt = ldc_pkg::GAP_CYC;
				st_nxt = fast_r[ch_r] ? ldc_pkg::S_IDLE : ldc_pkg::S_GAP; // RULE4
			end
			default: begin
				gap_nxt = gap_r - 3'h1;
				if (gap_r <= 3'h1) begin
					st_nxt = ldc_pkg::S_IDLE;
				end
			end
		endcase
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= ldc_pkg::S_IDLE;
			for (int i = 0; i < ldc_pkg::NCH; i++) begin
				ba_r[i] <= 24'h000000;
				bc_r[i] <= 16'h0000;
				ca_r[i] <= 24'h000000;
				cc_r[i] <= 16'h0000;
				md_r[i] <= 5'h00;
			end
			for (int i = 0; i < 3; i++) begin
				dcnt_r[i] <= 3'h0;
				dsh_r[i] <= 3'h0;
			end
			cmd_r <= 8'h00;
			mask_r <= ldc_pkg::MASK_RST;
			tcs_r <= 8'h00;
			fast_r <= 8'h00;
			rq_lpc_r <= 8'h00;
			rq_sb_r <= 8'h00;
			sbl_r <= 8'h00;
			skip_r <= 8'h00;
			ch_r <= 3'h0;
			gap_r <= 3'h0;
			gcnt_r <= 2'h0;
			sb_gnt_n <= 2'b11;
			bm_gnt <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 24'h000000;
			mem_wdata <= 16'h0000;
			dat_r <= 16'h0000;
			lst_r <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
			ba_r <= ba_nxt;
			bc_r <= bc_nxt;
			ca_r <= ca_nxt;
			cc_r <= cc_nxt;
			md_r <= md_nxt;
			dcnt_r <= dcnt_nxt;
			dsh_r <= dsh_nxt;
			cmd_r <= cmd_nxt;
			mask_r <= mask_nxt;
			tcs_r <= tcs_nxt;
			fast_r <= fast_nxt;
			rq_lpc_r <= rq_lpc_nxt;
			rq_sb_r <= rq_sb_nxt;
			sbl_r <= sbl_nxt;
			skip_r <= skip_nxt;
			ch_r <= ch_nxt;
			gap_r <= gap_nxt;
			gcnt_r <= gcnt_nxt;
			sb_gnt_n <= gnt_nxt;
			bm_gnt <= bm_nxt;
			mem_req <= mreq_nxt;
			mem_we <= mwe_nxt;
			mem_addr <= maddr_nxt;
			mem_wdata <= mwd_nxt;
			dat_r <= dat_nxt;
			lst_r <= lst_nxt;
			wb_ack_o <= ack_nxt;
			wb_dat_o <= rd_nxt;
		end
	end
	assign mem_wide = wide;
	chk_ack_one_cycle: assert property (@(posedge mclk) disable iff (!reset_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
	chk_fast_two_max: assert property (@(posedge mclk) disable iff (!reset_n) // RULE4
		ldc_pkg::ldc_popcnt(fast_r) <= 4'h2 && !fast_r[4]) else $error("too many fast channels");
	chk_ch4_no_lpc: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
		lst_r |-> ch_r != ldc_pkg::BM_CH) else $error("channel 4 ran a peripheral cycle");
	chk_bm_grant_src: assert property (@(posedge mclk) disable iff (!reset_n) // RULE5
		$rose(bm_gnt) |-> $past(pin_s_r[3]) && !$past(mask_r[4])) else $error("bus master grant without request");
	chk_byte_step: assert property (@(posedge mclk) disable iff (!reset_n) // RULE2
		(st_r == ldc_pkg::S_STEP && !wide && !tcn && !md[3]) |=>
		ca_r[$past(ch_r)] == $past(ca_r[ch_r]) + 24'h1 && cc_r[$past(ch_r)] == $past(cc_r[ch_r]) - 16'h1)
		else $error("byte channel step wrong");
	chk_word_step: assert property (@(posedge mclk) disable iff (!reset_n) // RULE3
		(st_r == ldc_pkg::S_STEP && wide && !tcn && !md[3]) |=>
		ca_r[$past(ch_r)] == $past(ca_r[ch_r]) + 24'h2) else $error("word channel step wrong");
	chk_tc_status: assert property (@(posedge mclk) disable iff (!reset_n) // RULE11
		(st_r == ldc_pkg::S_STEP && tcn) |=> tcs_r[$past(ch_r)] && (mask_r[$past(ch_r)] || $past(md[2])))
		else $error("terminal count not reported");
	chk_mask_readback: assert property (@(posedge mclk) disable iff (!reset_n) // RULE10
		(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == ldc_pkg::REG_MASK) |=>
		wb_ack_o && wb_dat_o[7:0] == $past(mask_r)) else $error("mask readback wrong");
	chk_sb_grant_frame: assert property (@(posedge mclk) disable iff (!reset_n) // RULE7
		(st_r == ldc_pkg::S_IDLE && st_nxt == ldc_pkg::S_GRANT) |=> !sb_gnt_n[sbl_r[ch_r]] ##4 sb_gnt_n == 2'b11)
		else $error("sideband grant frame wrong");
	chk_shared_engine: assert property (@(posedge mclk) disable iff (!reset_n) // RULE6 RULE9
		(st_r == ldc_pkg::S_IDLE && st_nxt != ldc_pkg::S_IDLE && st_nxt != ldc_pkg::S_BM) |->
		pend[ch_nxt]) else $error("unit started without pending request");
endmodule : ldc_top

// ---- tb/ldc_peer.sv ----
// ldc_peer: lpc and sideband peripheral that frames dma requests and answers lad with sync
// assumes the bench pulses go for one cycle and merges lad from both drivers
`timescale 1ns/1ns
module ldc_peer (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// bench control
	input wire logic go,
	input wire logic [2:0] ch,
	input wire logic [1:0] line,
	input wire logic prompt,
	// pins
	input wire logic lad_oe,
	output logic ldrq_n,
	output logic [1:0] sb_req_n,
	output logic [3:0] lad_drv
);
	logic [4:0] sr;
	logic [1:0] sel;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sr <= 5'h1F;
			sel <= 2'h0;
		end else if (go) begin
			sr <= {1'b1, ch, 1'b0};
			sel <= line;
		end else begin
			sr <= {1'b1, sr[4:1]};
		end
	end
	// idle serial lines sit at their pull-up level
	assign ldrq_n = (sel == 2'h0) ? sr[0] : 1'b1;
	assign sb_req_n = {(sel == 2'h2) ? sr[0] : 1'b1, (sel == 2'h1) ? sr[0] : 1'b1};
	// a slow peripheral never syncs, so the host must time out
	assign lad_drv = (!lad_oe && prompt) ? ldc_pkg::SYNC_READY : ldc_pkg::LAD_TAR;
endmodule : ldc_peer

// ---- tb/test_ldc_top.sv ----
// test_ldc_top: register, transfer and bus master checks of the dma engine
// assumes the peer model and a memory port answered here
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module test_ldc_top;
	logic mclk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, go = 0, prompt = 1, bm_req = 0, mem_ack = 0;
	logic gnt_seen = 0, hang = 0, ack, lad_oe, lframe_n, ldrq_n, bm_gnt, mem_req, mem_we, mem_wide;
	logic [8:0] adr = 9'h000;
	logic [31:0] dat = 32'h0, q, dat_o;
	logic [3:0] lad_out, lad_drv, lad_in;
	logic [2:0] pch = 3'h0;
	logic [1:0] line = 2'h0, sb_req_n, sb_gnt_n;
	logic [23:0] mem_addr, ea, st;
	logic [25:0] ma = 26'h0;
	logic [3:0] sel = 4'hF;
	logic [15:0] mem_wdata;
	int failures = 0, n_checks = 0;
	int chs[4] = '{1, 5, 2, 6};
	// verify single, to memory word, from memory decrement, verify autoinit
	logic [4:0] mds[4] = '{5'h10, 5'h01, 5'h0A, 5'h04};
	logic [1:0] lns[4] = '{2'h0, 2'h0, 2'h0, 2'h1};
	always #25 mclk = ~mclk;
	assign lad_in = lad_oe ? lad_out : lad_drv;
	always @(posedge mclk) mem_ack <= mem_req & !mem_ack;
	always @(posedge mclk) if (mem_req === 1'b1 && mem_ack === 1'b1) ma <= {mem_we, mem_wide, mem_addr};
	always @(posedge mclk) if (sb_gnt_n[0] === 1'b0) gnt_seen <= 1'b1;
	ldc_top i_dut (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.ldrq_n(ldrq_n), .lad_in(lad_in), .lad_out(lad_out), .lad_oe(lad_oe), .lframe_n(lframe_n),
		.sb_req_n(sb_req_n), .sb_gnt_n(sb_gnt_n), .bm_req(bm_req), .bm_gnt(bm_gnt), .mem_req(mem_req),
		.mem_we(mem_we), .mem_wide(mem_wide), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(16'h5AC3), .mem_ack(mem_ack));
	ldc_peer i_peer (.mclk(mclk), .reset_n(reset_n), .go(go), .ch(pch), .line(line), .prompt(prompt),
		.lad_oe(lad_oe), .ldrq_n(ldrq_n), .sb_req_n(sb_req_n), .lad_drv(lad_drv));
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	task wb(input logic w, input logic [8:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		// ack and read data are taken at the same rising edge, then the request drops
		for (i = 0; i < 20; i++) begin
			@(posedge mclk);
			if (ack === 1'b1) break;
		end
		if (i == 20) begin
			failures++;
			hang = 1'b1;
		end
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		wb(1'b0, ldc_pkg::REG_MASK, 32'h0); `CHK(q, 32'h000000FF)
		wb(1'b0, ldc_pkg::REG_CMD, 32'h0); `CHK(q, 32'h00000000)
		wb(1'b0, 9'h1F0, 32'h0); `CHK(q, 32'h00000000)
		wb(1'b1, {4'h7, ldc_pkg::CH_BASE_ADDR}, 32'hABCDEF);
		sel <= 4'h1;
		wb(1'b1, {4'h7, ldc_pkg::CH_BASE_ADDR}, 32'h12);
		sel <= 4'hF;
		wb(1'b0, {4'h7, ldc_pkg::CH_BASE_ADDR}, 32'h0); `CHK(q, 32'h00ABCD12)
		wb(1'b1, ldc_pkg::REG_FAST, 32'h13);
		wb(1'b0, ldc_pkg::REG_FAST, 32'h0); `CHK(q, 32'h00000003)
		wb(1'b1, ldc_pkg::REG_FAST, 32'h07);
		wb(1'b0, ldc_pkg::REG_FAST, 32'h0); `CHK(q, 32'h00000003)
		wb(1'b1, ldc_pkg::REG_CMD, 32'h1);
		// count 1 gives two units and a step before terminal count; autoinit runs one unit from count 0
		for (int k = 0; k < 4; k++) begin
			prompt <= (k != 2);
			wb(1'b1, {1'b0, 3'(chs[k]), ldc_pkg::CH_CUR_ADDR}, 32'h100);
			wb(1'b1, {1'b0, 3'(chs[k]), ldc_pkg::CH_CUR_CNT}, {31'h0, !mds[k][2]});
			wb(1'b1, {1'b0, 3'(chs[k]), ldc_pkg::CH_MODE}, {27'h0, mds[k]});
			wb(1'b1, ldc_pkg::REG_MASK, {24'h0, ~(8'h01 << chs[k])});
			pch <= 3'(chs[k]);
			line <= lns[k];
			go <= 1'b1;
			@(posedge mclk);
			go <= 1'b0;
			q = 32'h0;
			for (int i = 0; i < 300 && q[chs[k]] !== 1'b1; i++) wb(1'b0, ldc_pkg::REG_STATUS, 32'h0);
			`CHK(q[chs[k]], 1'b1)
			st = (chs[k] > 3) ? 24'h2 : 24'h1;
			ea = mds[k][3] ? 24'h100 - st : 24'h100 + st;
			if (mds[k][1:0] != 2'h0) `CHK(ma, {mds[k][1:0] == 2'h1, chs[k] > 3, ea})
			ea = mds[k][2] ? 24'h0 : mds[k][3] ? ea - st : ea + st;
			wb(1'b0, {1'b0, 3'(chs[k]), ldc_pkg::CH_CUR_ADDR}, 32'h0); `CHK(q[23:0], ea)
			wb(1'b0, {1'b0, 3'(chs[k]), ldc_pkg::CH_CUR_CNT}, 32'h0);
			`CHK(q, mds[k][2] ? 32'h00000000 : 32'h0000FFFF)
			wb(1'b0, ldc_pkg::REG_MASK, 32'h0); `CHK(q[7:0], mds[k][2] ? ~(8'h01 << chs[k]) : 8'hFF)
			wb(1'b1, ldc_pkg::REG_STATUS, 32'h0);
		end
		`CHK(gnt_seen, 1'b1)
		wb(1'b1, ldc_pkg::REG_MASK, 32'hEF);
		bm_req <= 1'b1;
		for (int i = 0; i < 12 && bm_gnt !== 1'b1; i++) @(negedge mclk);
		`CHK(bm_gnt, 1'b1)
		@(posedge mclk);
		bm_req <= 1'b0;
		for (int i = 0; i < 12 && bm_gnt !== 1'b0; i++) @(negedge mclk);
		`CHK(bm_gnt, 1'b0)
		wrap_up();
	end
	// a bus wait that runs out or the overall limit both end here
	initial begin
		for (int c = 0; c < 90000 && !hang; c++) @(posedge mclk);
		if (!hang) failures++;
		wrap_up();
	end
endmodule : test_ldc_top
